// ---- verilog/ptu_timer_regs.vh ----
// register map, field positions and reset values of the pulse timer unit
`ifndef PTU_TIMER_REGS_VH
`define PTU_TIMER_REGS_VH

// global words (byte addresses)
`define PTU_MSTOP_ADR 12'h000
`define PTU_GSTAT_ADR 12'h004
`define PTU_GCLR_ADR 12'h008
`define PTU_GEN_ADR 12'h00C
// channel blocks: base + channel * stride
`define PTU_CH_BASE 12'h040
`define PTU_CH_STRIDE 12'h040
// word offsets inside a channel block, as adr[5:2]
`define PTU_OFS_CTRL 4'h0
`define PTU_OFS_IER 4'h1
`define PTU_OFS_STAT 4'h2
`define PTU_OFS_CNT 4'h3
`define PTU_OFS_IOC 4'h4
`define PTU_OFS_GRA 4'h5
// channel control fields
`define PTU_CTL_RUN 0
`define PTU_CTL_DOWN 1
`define PTU_CTL_EXT 2
`define PTU_CTL_BOTH 3
`define PTU_CTL_CLRA 4
// interrupt enable fields; capcmp enables are bits 3:0
`define PTU_IER_OVF 4
`define PTU_IER_UNF 5
`define PTU_IER_ADC 7
`define PTU_IER_XFER_LO 8
// status fields; capcmp flags are bits 3:0
`define PTU_ST_OVF 4
`define PTU_ST_UNF 5
// io control: bits 3:0 capture select, bits 5:4 output action of reg a
`define PTU_IOC_OUT_LO 4
`define PTU_OUT_KEEP 2'h0
`define PTU_OUT_LOW 2'h1
`define PTU_OUT_HIGH 2'h2
`define PTU_OUT_TOGGLE 2'h3
// reset value and counter limits
`define PTU_MSTOP_RST 1'b1
`define PTU_CNT_MAX 16'hFFFF
`define PTU_CNT_MIN 16'h0000

`endif

// ---- verilog/ptu_timer_events.v ----
// six-channel 16-bit pulse timer: counters, compare/capture, event flags
// Behaviour
// - sixteen capcmp sources, each its own flag
// - capcmp flag with enable raises capcmp request
// - overflow flag per channel, gated request
// - underflow flag only channels 1,2,4,5
// - only capcmp sources start transfer controller
// - register a match plus enable starts adc
// - register a match at last equal state drives output
// - one match per counter input clock
// - flag cleared by read one, write zero
// - transfer controller done pulse clears its flag
// - module stop set at reset, blocks access
// - clear on match gives period n+1 when counting up
// - clear beats counter write in same cycle
`timescale 1ns/100ps
`include "ptu_timer_regs.vh"

module ptu_timer_events (
  // clock and reset
  input wire clock,
  input wire reset_n,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // timer pins
  input wire [5:0] ext_clk,
  input wire [15:0] capture_in,
  output reg [5:0] compare_out,
  // requests to interrupt controller
  output reg [15:0] capcmp_irq,
  output reg [5:0] overflow_irq,
  output reg [3:0] underflow_irq,
  output reg irq,
  // transfer controller and adc
  output reg [15:0] xfer_req,
  input wire [15:0] xfer_done,
  output reg [5:0] adc_start
);

  reg mstop_q;
  reg [7:0] ctrl_q [0:5];
  reg [15:0] ier_q [0:5];
  reg [5:0] stat_q [0:5];
  reg [5:0] arm_q [0:5];
  reg [5:0] ioc_q [0:5];
  reg [15:0] cnt_q [0:5];
  reg [15:0] gr_q [0:23];
  reg [5:0] gstat_q;
  reg [5:0] gen_q;
  reg [5:0] ext_s1_q, ext_s2_q, ext_s3_q, ext_lvl_q;
  reg [15:0] cap_s1_q, cap_s2_q, cap_s3_q, cap_lvl_q;

  reg [35:0] set_d;
  reg [95:0] cnt_d;
  reg [5:0] cmpa_d;
  reg [5:0] clr_d;
  reg [15:0] cap_ev;
  reg [31:0] rdata;

  function has_unf;
    input integer c;
    has_unf = (c != 0) && (c != 3);
  endfunction

  function has_reg;
    input integer c;
    input integer n;
    has_reg = (n < 2) || (c == 0) || (c == 3);
  endfunction

  // position of a capcmp source in the 16-wide vectors
  function integer src_idx;
    input integer c;
    input integer n;
    case (c)
      0: src_idx = n;
      1: src_idx = 4 + n;
      2: src_idx = 6 + n;
      3: src_idx = 8 + n;
      4: src_idx = 12 + n;
      default: src_idx = 14 + n;
    endcase
  endfunction

  function [5:0] stat_mask;
    input integer c;
    stat_mask = {has_unf(c), 1'b1, has_reg(c, 3), has_reg(c, 2), 2'b11};
  endfunction

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] sel;
    merge16 = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
  endfunction

  // bus decode
  wire req = wb_cyc_i & wb_stb_i;
  wire wr_fire = req & wb_ack_o & wb_we_i;
  wire rd_fire = req & wb_ack_o & ~wb_we_i;
  wire [2:0] blk = wb_adr_i[8:6];
  wire in_ch = (wb_adr_i[11:9] == 3'h0) && (blk >= 3'h1) && (blk <= 3'h6);
  wire [2:0] sel_ch = blk - 3'h1;
  wire [3:0] ofs = wb_adr_i[5:2];
  wire is_glob = (wb_adr_i[11:4] == 8'h00);
  wire [5:0] ext_chg = ~(ext_s2_q ^ ext_s3_q) & (ext_s3_q ^ ext_lvl_q);
  wire [15:0] cap_chg = ~(cap_s2_q ^ cap_s3_q) & (cap_s3_q ^ cap_lvl_q);

  // counting, compare and capture events
  always @* begin : events
    integer ch, r, k;
    ch = 0;
    r = 0;
    k = 0;
    set_d = 36'h0_0000_0000;
    cnt_d = 96'h0;
    cmpa_d = 6'h00;
    clr_d = 6'h00;
    cap_ev = 16'h0000;
    for (ch = 0; ch < 6; ch = ch + 1) begin
      begin : chan
        reg tick;
        reg down;
        reg cmp;
        reg cnt_wr;
        reg [15:0] c;
        tick = 1'b0;
        down = 1'b0;
        cmp = 1'b0;
        cnt_wr = 1'b0;
        c = cnt_q[ch];
        if (ctrl_q[ch][`PTU_CTL_RUN] && !mstop_q) begin
          if (!ctrl_q[ch][`PTU_CTL_EXT])
            tick = 1'b1;
          else if (ctrl_q[ch][`PTU_CTL_BOTH])
            tick = ext_chg[ch];
          else
            tick = ext_chg[ch] & ext_s3_q[ch];
        end
        down = ctrl_q[ch][`PTU_CTL_DOWN] & has_unf(ch);
        for (r = 0; r < 4; r = r + 1) begin
          if (has_reg(ch, r)) begin
            k = src_idx(ch, r);
            if (ioc_q[ch][r]) begin
              cap_ev[k] = cap_chg[k] & cap_s3_q[k] & ~mstop_q;
              set_d[ch*6+r] = cap_ev[k];
            end else begin
              // only at the update point: one match per input clock
              cmp = tick && (c == gr_q[ch*4+r]);
              set_d[ch*6+r] = cmp;
              if (r == 0) begin
                cmpa_d[ch] = cmp;
                clr_d[ch] = cmp & ctrl_q[ch][`PTU_CTL_CLRA];
              end
            end
          end
        end
        cnt_wr = wr_fire && in_ch && !mstop_q && (sel_ch == ch) &&
                 (ofs == `PTU_OFS_CNT);
        // clear outranks overflow and a write in the same cycle
        if (!clr_d[ch] && !cnt_wr) begin
          set_d[ch*6+`PTU_ST_OVF] = tick & ~down & (c == `PTU_CNT_MAX);
          set_d[ch*6+`PTU_ST_UNF] = tick & down & (c == `PTU_CNT_MIN);
        end
        if (clr_d[ch])
          cnt_d[ch*16 +: 16] = 16'h0000;
        else if (cnt_wr)
          cnt_d[ch*16 +: 16] = merge16(c, wb_dat_i, wb_sel_i);
        else if (tick)
          cnt_d[ch*16 +: 16] = down ? c - 16'h0001 : c + 16'h0001;
        else
          cnt_d[ch*16 +: 16] = c;
      end
    end
  end

  // read mux; all registers but module stop hidden while module stop is set
  always @* begin
    rdata = 32'h0000_0000;
    if (is_glob) begin
      case (wb_adr_i)
        `PTU_MSTOP_ADR: rdata = {31'h0, mstop_q};
        `PTU_GSTAT_ADR: rdata = mstop_q ? 32'h0 : {26'h0, gstat_q};
        `PTU_GEN_ADR: rdata = mstop_q ? 32'h0 : {26'h0, gen_q};
        default: rdata = 32'h0000_0000;
      endcase
    end else if (in_ch && !mstop_q) begin
      case (ofs)
        `PTU_OFS_CTRL: rdata = {24'h0, ctrl_q[sel_ch]};
        `PTU_OFS_IER: rdata = {16'h0, ier_q[sel_ch]};
        `PTU_OFS_STAT: rdata = {26'h0, stat_q[sel_ch]};
        `PTU_OFS_CNT: rdata = {16'h0, cnt_q[sel_ch]};
        `PTU_OFS_IOC: rdata = {26'h0, ioc_q[sel_ch]};
        4'h5, 4'h6, 4'h7, 4'h8:
          if (has_reg(sel_ch, ofs - `PTU_OFS_GRA))
            rdata = {16'h0, gr_q[sel_ch*4 + ofs - `PTU_OFS_GRA]};
        default: rdata = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge clock or negedge reset_n) begin : regs
    integer ch, r;
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      mstop_q <= `PTU_MSTOP_RST;
      gstat_q <= 6'h00;
      gen_q <= 6'h00;
      ext_s1_q <= 6'h00;
      ext_s2_q <= 6'h00;
      ext_s3_q <= 6'h00;
      cap_s1_q <= 16'h0000;
      cap_s2_q <= 16'h0000;
      cap_s3_q <= 16'h0000;
      ext_lvl_q <= 6'h00;
      cap_lvl_q <= 16'h0000;
      compare_out <= 6'h00;
      capcmp_irq <= 16'h0000;
      overflow_irq <= 6'h00;
      underflow_irq <= 4'h0;
      irq <= 1'b0;
      xfer_req <= 16'h0000;
      adc_start <= 6'h00;
      for (ch = 0; ch < 6; ch = ch + 1) begin
        ctrl_q[ch] <= 8'h00;
        ier_q[ch] <= 16'h0000;
        stat_q[ch] <= 6'h00;
        arm_q[ch] <= 6'h00;
        ioc_q[ch] <= 6'h00;
        cnt_q[ch] <= 16'h0000;
      end
      for (r = 0; r < 24; r = r + 1)
        gr_q[r] <= 16'hFFFF;
    end else begin
      ext_s1_q <= ext_clk;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      cap_s1_q <= capture_in;
      cap_s2_q <= cap_s1_q;
      cap_s3_q <= cap_s2_q;
      ext_lvl_q <= ext_lvl_q ^ ext_chg;
      cap_lvl_q <= cap_lvl_q ^ cap_chg;
      // one wait state: data sampled the cycle before ack
      wb_ack_o <= req & ~wb_ack_o;
      if (req && !wb_ack_o)
        wb_dat_o <= rdata;
      if (wr_fire && is_glob && wb_adr_i == `PTU_MSTOP_ADR && wb_sel_i[0])
        mstop_q <= wb_dat_i[0];
      if (wr_fire && is_glob && !mstop_q && wb_adr_i == `PTU_GEN_ADR &&
          wb_sel_i[0])
        gen_q <= wb_dat_i[5:0];
      for (ch = 0; ch < 6; ch = ch + 1) begin
        cnt_q[ch] <= cnt_d[ch*16 +: 16];
        // set wins over every clear path
        gstat_q[ch] <= (|set_d[ch*6 +: 6]) | (gstat_q[ch] &
          ~(wr_fire && is_glob && !mstop_q && wb_sel_i[0] &&
            wb_adr_i == `PTU_GCLR_ADR && wb_dat_i[ch]));
        if (cmpa_d[ch]) begin
          case (ioc_q[ch][`PTU_IOC_OUT_LO +: 2])
            `PTU_OUT_LOW: compare_out[ch] <= 1'b0;
            `PTU_OUT_HIGH: compare_out[ch] <= 1'b1;
            `PTU_OUT_TOGGLE: compare_out[ch] <= ~compare_out[ch];
            default: compare_out[ch] <= compare_out[ch];
          endcase
        end
        adc_start[ch] <= set_d[ch*6] & ier_q[ch][`PTU_IER_ADC];
        begin : flags
          reg [5:0] clr;
          reg [5:0] st;
          clr = 6'h00;
          st = stat_q[ch];
          for (r = 0; r < 4; r = r + 1)
            if (has_reg(ch, r))
              clr[r] = xfer_done[src_idx(ch, r)] &
                       ier_q[ch][`PTU_IER_XFER_LO + r];
          if (wr_fire && in_ch && !mstop_q && sel_ch == ch &&
              ofs == `PTU_OFS_STAT && wb_sel_i[0]) begin
            clr = clr | (arm_q[ch] & ~wb_dat_i[5:0]);
            arm_q[ch] <= 6'h00;
          end else if (rd_fire && in_ch && !mstop_q && sel_ch == ch &&
                       ofs == `PTU_OFS_STAT)
            arm_q[ch] <= arm_q[ch] | st;
          else
            arm_q[ch] <= arm_q[ch] & st;
          st = ((st & ~clr) | set_d[ch*6 +: 6]) & stat_mask(ch);
          stat_q[ch] <= st;
          overflow_irq[ch] <= st[`PTU_ST_OVF] & ier_q[ch][`PTU_IER_OVF];
          for (r = 0; r < 4; r = r + 1)
            if (has_reg(ch, r)) begin
              capcmp_irq[src_idx(ch, r)] <= st[r] & ier_q[ch][r];
              // overflow and underflow have no path here
              xfer_req[src_idx(ch, r)] <= st[r] & ier_q[ch][r] &
                ier_q[ch][`PTU_IER_XFER_LO + r];
            end
          if (ch == 1 || ch == 2)
            underflow_irq[ch-1] <= st[`PTU_ST_UNF] & ier_q[ch][`PTU_IER_UNF];
          if (ch == 4 || ch == 5)
            underflow_irq[ch-2] <= st[`PTU_ST_UNF] & ier_q[ch][`PTU_IER_UNF];
        end
        if (cap_ev[src_idx(ch, 0)] && ioc_q[ch][0])
          gr_q[ch*4] <= cnt_q[ch];
        for (r = 1; r < 4; r = r + 1)
          if (has_reg(ch, r) && ioc_q[ch][r] && cap_ev[src_idx(ch, r)])
            gr_q[ch*4+r] <= cnt_q[ch];
        if (wr_fire && in_ch && !mstop_q && sel_ch == ch) begin
          case (ofs)
            `PTU_OFS_CTRL:
              if (wb_sel_i[0])
                ctrl_q[ch] <= wb_dat_i[7:0];
            `PTU_OFS_IER: ier_q[ch] <= merge16(ier_q[ch], wb_dat_i, wb_sel_i);
            `PTU_OFS_IOC:
              if (wb_sel_i[0])
                ioc_q[ch] <= wb_dat_i[5:0];
            4'h5, 4'h6, 4'h7, 4'h8:
              if (has_reg(ch, ofs - `PTU_OFS_GRA))
                gr_q[ch*4 + ofs - `PTU_OFS_GRA] <=
                  merge16(gr_q[ch*4 + ofs - `PTU_OFS_GRA], wb_dat_i, wb_sel_i);
            default: ;
          endcase
        end
      end
      irq <= |(gstat_q & gen_q);
    end
  end

endmodule // ptu_timer_events

// ---- dv/ptu_timer_events_assertions.sv ----
// port-level assertions for the timer event logic
`timescale 1ns/100ps
module ptu_timer_events_assertions (
  // clock and reset
  input wire clock,
  input wire reset_n,
  // bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // requests
  input wire [15:0] capcmp_irq,
  input wire [5:0] overflow_irq,
  input wire [15:0] xfer_req,
  input wire [15:0] xfer_done,
  input wire [5:0] adc_start
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_ack_next_cycle: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_one_pulse: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_has_cause: assert property (
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  a_read_data_held: assert property (
    !(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o)) else $error("data moved");
  a_adc_one_pulse: assert property (
    |adc_start |=> (adc_start & $past(adc_start)) == 6'h00)
    else $error("adc pulse too long");
  a_xfer_needs_irq: assert property (
    (xfer_req & ~capcmp_irq) == 16'h0000) else $error("xfer without irq");
  a_xfer_done_clears: assert property (
    |(xfer_done & xfer_req) |->
    ##2 (xfer_req & $past(xfer_done & xfer_req, 2)) == 16'h0000)
    else $error("request kept after done");
  a_request_sticky: assert property (
    |($past({capcmp_irq, overflow_irq}) & ~{capcmp_irq, overflow_irq}) |->
    $past(wb_ack_o && wb_we_i) || $past(|xfer_done))
    else $error("request dropped without clear");
endmodule // ptu_timer_events_assertions

// ---- dv/ptu_xfer_model.sv ----
// transfer controller stand-in: one done pulse per request after a delay
`timescale 1ns/100ps
module ptu_xfer_model #(
  parameter DELAY = 2
) (
  // clock and reset
  input wire clock,
  input wire reset_n,
  // request side
  input wire [15:0] xfer_req,
  output reg [15:0] xfer_done
);
  reg [15:0] sel_q;
  reg sent_q;
  integer cnt_q;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      xfer_done <= 16'h0000;
      sel_q <= 16'h0000;
      sent_q <= 1'b0;
      cnt_q <= 0;
    end else begin
      xfer_done <= 16'h0000;
      if (sel_q == 16'h0000) begin
        // lowest pending source first
        sel_q <= xfer_req & ~(xfer_req - 16'h0001);
        cnt_q <= DELAY;
      end else if (cnt_q != 0) begin
        cnt_q <= cnt_q - 1;
      end else if (!sent_q) begin
        xfer_done <= sel_q;
        sent_q <= 1'b1;
      end else if ((xfer_req & sel_q) == 16'h0000) begin
        // request lags the done pulse, so wait for it to drop
        sel_q <= 16'h0000;
        sent_q <= 1'b0;
      end
    end
  end
endmodule // ptu_xfer_model

// ---- dv/ptu_timer_events_tb_top.sv ----
// testbench top for the pulse timer event logic
`timescale 1ns/100ps
`include "ptu_timer_regs.vh"
module ptu_timer_events_tb_top;
  reg clock = 1'b0;
  reg reset_n = 1'b0;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [11:0] wb_adr_i = 12'h000;
  reg [31:0] wb_dat_i = 32'h0000_0000;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire [15:0] capcmp_irq;
  wire [5:0] overflow_irq;
  wire [5:0] compare_out;
  wire [3:0] underflow_irq;
  wire irq;
  wire [15:0] xfer_req;
  wire [15:0] xfer_done;
  wire [5:0] adc_start;
  integer mismatches = 0;
  integer n_checks = 0;
  integer i;
  time t0;
  reg [31:0] rd;
  always #10 clock = ~clock;
  // ext clock pins held still, so pulse width limits hold trivially
  ptu_timer_events ptu_timer_events_i (.clock(clock), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk(6'h00),
    .capture_in(16'h0000), .compare_out(compare_out),
    .capcmp_irq(capcmp_irq),
    .overflow_irq(overflow_irq), .underflow_irq(underflow_irq), .irq(irq),
    .xfer_req(xfer_req), .xfer_done(xfer_done), .adc_start(adc_start));
  ptu_xfer_model ptu_xfer_model_i (.clock(clock), .reset_n(reset_n),
    .xfer_req(xfer_req), .xfer_done(xfer_done));
  task automatic bus(input [11:0] a, input w, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
        @(posedge clock);
        n = n + 1;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (n >= 50) mismatches = mismatches + 1;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  function [11:0] ca(input integer ch, input [3:0] o);
    ca = `PTU_CH_BASE + 12'(ch) * `PTU_CH_STRIDE + {6'h00, o, 2'h0};
  endfunction
  task report_and_stop;
    begin
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    mismatches = mismatches + 1;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    chk({capcmp_irq, xfer_req}, 32'h0000_0000);
    bus(`PTU_MSTOP_ADR, 0, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    bus(ca(0, `PTU_OFS_IER), 1, 32'h0000_0081);
    bus(ca(0, `PTU_OFS_IER), 0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    bus(`PTU_MSTOP_ADR, 1, 32'h0000_0000);
    bus(12'h030, 0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    // ch0: match on reg a every n+1 cycles, adc pulse each time
    bus(ca(0, `PTU_OFS_GRA), 1, 32'h0000_0004);
    bus(ca(0, `PTU_OFS_IOC), 1, 32'h0000_0020);
    bus(ca(0, `PTU_OFS_IER), 1, 32'h0000_0081);
    bus(ca(0, `PTU_OFS_CTRL), 1, 32'h0000_0011);
    for (i = 0; i < 40 && adc_start[0] !== 1'b1; i = i + 1) @(posedge clock);
    t0 = $time;
    @(posedge clock);
    for (i = 0; i < 40 && adc_start[0] !== 1'b1; i = i + 1) @(posedge clock);
    chk(32'(($time - t0) / 20), 32'h0000_0005);
    chk({30'h0000_0000, compare_out[0], capcmp_irq[0]}, 32'h0000_0003);
    bus(ca(0, `PTU_OFS_CTRL), 1, 32'h0000_0000);
    // a write without the arming read must not clear
    bus(ca(0, `PTU_OFS_STAT), 1, 32'h0000_0000);
    bus(ca(0, `PTU_OFS_STAT), 0, 32'h0000_0000);
    chk(rd & 32'h0000_000F, 32'h0000_0001);
    bus(ca(0, `PTU_OFS_STAT), 1, 32'h0000_0000);
    bus(ca(0, `PTU_OFS_STAT), 0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    repeat (3) @(posedge clock);
    chk({16'h0000, capcmp_irq}, 32'h0000_0000);
    // match every cycle at zero, so every count write meets a clear
    bus(ca(0, `PTU_OFS_IER), 1, 32'h0000_0000);
    bus(ca(0, `PTU_OFS_GRA), 1, 32'h0000_0000);
    bus(ca(0, `PTU_OFS_CNT), 1, 32'h0000_0000);
    bus(ca(0, `PTU_OFS_CTRL), 1, 32'h0000_0011);
    bus(ca(0, `PTU_OFS_CNT), 1, 32'h0000_1234);
    bus(ca(0, `PTU_OFS_CNT), 0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    bus(ca(0, `PTU_OFS_CTRL), 1, 32'h0000_0000);
    // ch1 overflow, ch2 underflow
    bus(ca(1, `PTU_OFS_IER), 1, 32'h0000_0010);
    bus(ca(1, `PTU_OFS_CNT), 1, 32'h0000_FFFE);
    bus(ca(1, `PTU_OFS_CTRL), 1, 32'h0000_0001);
    for (i = 0; i < 20 && overflow_irq[1] !== 1'b1; i = i + 1) @(posedge clock);
    bus(ca(1, `PTU_OFS_STAT), 0, 32'h0000_0000);
    chk(rd & 32'h0000_0030, 32'h0000_0010);
    chk({26'h000_0000, overflow_irq}, 32'h0000_0002);
    bus(ca(1, `PTU_OFS_CTRL), 1, 32'h0000_0000);
    bus(ca(2, `PTU_OFS_IER), 1, 32'h0000_0020);
    bus(ca(2, `PTU_OFS_CNT), 1, 32'h0000_0001);
    bus(ca(2, `PTU_OFS_CTRL), 1, 32'h0000_0003);
    for (i = 0; i < 20 && underflow_irq[1] !== 1'b1; i = i + 1)
      @(posedge clock);
    chk({28'h000_0000, underflow_irq}, 32'h0000_0002);
    bus(ca(2, `PTU_OFS_CTRL), 1, 32'h0000_0000);
    // ch3 reg a routed to the transfer controller
    bus(ca(3, `PTU_OFS_GRA), 1, 32'h0000_0003);
    bus(ca(3, `PTU_OFS_IER), 1, 32'h0000_0101);
    bus(ca(3, `PTU_OFS_CTRL), 1, 32'h0000_0001);
    for (i = 0; i < 40 && xfer_req[8] !== 1'b1; i = i + 1) @(posedge clock);
    chk({30'h0000_0000, capcmp_irq[8], xfer_req[8]}, 32'h0000_0003);
    for (i = 0; i < 40 && xfer_req[8] !== 1'b0; i = i + 1) @(posedge clock);
    bus(ca(3, `PTU_OFS_CTRL), 1, 32'h0000_0000);
    bus(ca(3, `PTU_OFS_STAT), 0, 32'h0000_0000);
    chk(rd & 32'h0000_0001, 32'h0000_0000);
    // summary interrupt: raise, mask, clear
    bus(`PTU_GEN_ADR, 1, 32'h0000_0001);
    repeat (3) @(posedge clock);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    bus(`PTU_GEN_ADR, 1, 32'h0000_0000);
    repeat (3) @(posedge clock);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    bus(`PTU_GEN_ADR, 1, 32'h0000_0001);
    bus(`PTU_GCLR_ADR, 1, 32'h0000_0001);
    repeat (3) @(posedge clock);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    bus(`PTU_GSTAT_ADR, 0, 32'h0000_0000);
    chk(rd & 32'h0000_0001, 32'h0000_0000);
    report_and_stop;
  end
endmodule // ptu_timer_events_tb_top
bind ptu_timer_events ptu_timer_events_assertions
  ptu_timer_events_assertions_i (.clock(clock), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .capcmp_irq(capcmp_irq),
  .overflow_irq(overflow_irq), .xfer_req(xfer_req),
  .xfer_done(xfer_done), .adc_start(adc_start));
